// ==== dv/cts_ctrl_model.sv ====
/*
 Controller-side model: drives the transmit bit and both mode selects.
 Assumes the bench calls its tasks just after a rising hclk edge.
*/
`default_nettype none

module cts_ctrl_model (
	// Clock
	input  wire logic hclk,
	// Pins towards the transceiver
	output logic      txd,
	output logic      txd_driven,
	output logic      en,
	output logic      en_driven,
	output logic      low_power_select_n,
	output logic      low_power_select_driven
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] sel_reg;
	logic       drv_reg;
	logic       txd_reg;

	initial
	begin
		sel_reg = 2'h0;
		drv_reg = 1'b1;
		txd_reg = 1'b1;
		txd = 1'b1;
		en = 1'b0;
		low_power_select_n = 1'b0;
		txd_driven = 1'b1;
		en_driven = 1'b1;
		low_power_select_driven = 1'b1;
	end

	always @(posedge hclk)
	begin
		txd_driven <= drv_reg;
		en_driven <= drv_reg;
		low_power_select_driven <= drv_reg;
		if (drv_reg)
		begin
			low_power_select_n <= sel_reg[1];
			en <= sel_reg[0];
			txd <= txd_reg;
		end
		else
		begin
			// Released lines carry junk so a stale level cannot pass
			txd <= ~txd;
			en <= ~en;
			low_power_select_n <= ~low_power_select_n;
		end
	end

	task automatic set_mode(input logic [1:0] s);
		sel_reg <= s;
		drv_reg <= 1'b1;
	endtask

	task automatic float_pins();
		drv_reg <= 1'b0;
	endtask

	// Each level held three cycles to clear the synchroniser
	task automatic txd_falls(input int n);
		repeat (n)
		begin
			txd_reg <= 1'b0;
			repeat (3) @(posedge hclk);
			txd_reg <= 1'b1;
			repeat (3) @(posedge hclk);
		end
	endtask
endmodule

`default_nettype wire

// ==== dv/cts_top_tb_top.sv ====
/*
 Self-checking bench of the transceiver status and wake logic.
 Assumes a zero-wait AHB-Lite slave and the controller model.
*/
`default_nettype none

module cts_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [1:0]  sel;
		logic [31:0] st;
		logic [4:0]  pins;
	} cts_row_t;

	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  fault;
	logic        txd, txd_driven, en, en_driven, lps_n, lps_driven;
	logic        rxd, sin_n, sin_oe, sup_out, sup_oe;
	logic        wake_pin, bus_wake, bus_rx, vsup_uv, vcc_uv, vio_uv;
	int          bad_count, checked, cycles;
	cts_row_t    rows [5];

	assign hready = hreadyout;

	cts_top #(.UV_CYC(4)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .txd(txd), .txd_driven(txd_driven),
		.en(en), .en_driven(en_driven), .low_power_select_n(lps_n),
		.low_power_select_driven(lps_driven), .rxd(rxd), .status_indicator_n(sin_n),
		.status_indicator_oe(sin_oe), .local_pin_wakeup(wake_pin), .bus_wake(bus_wake),
		.bus_rx(bus_rx), .vsup_uv(vsup_uv), .transceiver_supply_uv(vcc_uv),
		.vio_uv(vio_uv), .fault(fault), .supply_control_out(sup_out),
		.supply_control_oe(sup_oe)
	);

	cts_ctrl_model model (
		.hclk(hclk), .txd(txd), .txd_driven(txd_driven), .en(en), .en_driven(en_driven),
		.low_power_select_n(lps_n), .low_power_select_driven(lps_driven)
	);

	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t ns: %s got %h wanted %h", $time, msg, got, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		d = hrdata;
	endtask

	// Indicator level ignored while it floats
	task automatic look(input logic [31:0] st, input logic [4:0] pins, input string msg);
		logic [31:0] d;
		ahb(1'b0, 32'h0000_0000, 32'h0000_0000, d);
		chk(d, st, msg);
		chk({27'h0, rxd, sin_oe ? sin_n : 1'b1, sin_oe, sup_out, sup_oe}, {27'h0, pins}, msg);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			bad_count++;
			$display("unexpected at %0t ns: run did not finish", $time);
			wrap_up();
		end
	end

	initial
	begin
		{hresetn, hsel, hwrite, haddr, hwdata, htrans, fault} = '0;
		{wake_pin, bus_wake, vsup_uv, vcc_uv, vio_uv} = 5'h00;
		hsize = 3'h2;
		bus_rx = 1'b1;
		bad_count = 0;
		checked = 0;
		cycles = 0;
		rows = '{'{2'h1, 32'h0000_2F04, 5'h07}, '{2'h3, 32'h0000_2C01, 5'h17},
			'{2'h2, 32'h0000_2802, 5'h1F}, '{2'h0, 32'h0000_2804, 5'h1F},
			'{2'h1, 32'h0000_2810, 5'h1A}};
		cyc(16);
		chk({27'h0, rxd, sin_n, sin_oe, sup_out, sup_oe}, 32'h0000_001F, "in reset");
		hresetn <= 1'b1;
		cyc(8);
		look(32'h0000_2F04, 5'h07, "power-up flags");
		ahb(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0032, "control reset value");
		ahb(1'b1, 32'h0000_0004, 32'h0000_0002, rd);
		ahb(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0002, "control write");
		ahb(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000, "unmapped read");
		ahb(1'b1, 32'h0000_0000, 32'hFFFF_FFFF, rd);
		look(32'h0000_2F04, 5'h07, "status write ignored");
		$display("test registers done");
		foreach (rows[i])
		begin
			model.set_mode(rows[i].sel);
			cyc(12);
			look(rows[i].st, rows[i].pins, "mode row");
		end
		$display("test mode table done");
		wake_pin <= 1'b1;
		cyc(12);
		look(32'h0000_2E04, 5'h07, "local wake in sleep");
		bus_wake <= 1'b1;
		cyc(12);
		look(32'h0000_2E04, 5'h07, "later bus wake");
		bus_wake <= 1'b0;
		model.set_mode(2'h3);
		cyc(12);
		look(32'h0000_2C01, 5'h17, "local source shown");
		model.txd_falls(3);
		cyc(4);
		look(32'h0000_2C01, 5'h17, "three transmit falls");
		model.txd_falls(1);
		cyc(4);
		look(32'h0000_2801, 5'h1F, "fourth transmit fall");
		$display("test local wake done");
		model.set_mode(2'h0);
		cyc(12);
		model.set_mode(2'h1);
		cyc(12);
		bus_wake <= 1'b1;
		cyc(12);
		look(32'h0000_2604, 5'h07, "bus wake in sleep");
		model.set_mode(2'h3);
		cyc(12);
		look(32'h0000_2401, 5'h1F, "remote source shown");
		wake_pin <= 1'b0;
		bus_rx <= 1'b0;
		cyc(12);
		look(32'h0000_2401, 5'h0F, "wake pin in normal");
		fault <= 4'h4;
		bus_rx <= 1'b1;
		cyc(12);
		look(32'h0000_3401, 5'h17, "fault shown");
		fault <= 4'h0;
		bus_wake <= 1'b0;
		$display("test remote wake done");
		model.float_pins();
		cyc(12);
		look(32'h0000_2004, 5'h1F, "floating pins");
		model.set_mode(2'h0);
		vsup_uv <= 1'b1;
		cyc(12);
		vsup_uv <= 1'b0;
		cyc(12);
		look(32'h0000_2F04, 5'h07, "battery recovery");
		model.set_mode(2'h2);
		cyc(12);
		look(32'h0000_2F02, 5'h17, "silent after standby");
		vio_uv <= 1'b1;
		fault <= 4'h9;
		cyc(12);
		look(32'h0000_3902, 5'h17, "sustained undervoltage");
		vio_uv <= 1'b0;
		fault <= 4'h0;
		model.set_mode(2'h0);
		cyc(12);
		bus_wake <= 1'b1;
		vcc_uv <= 1'b1;
		cyc(12);
		look(32'h0000_2104, 5'h1F, "supply undervoltage clears request");
		bus_wake <= 1'b0;
		vcc_uv <= 1'b0;
		$display("test cold start done");
		wrap_up();
	end
endmodule

`default_nettype wire

// ==== hw/cts_map.svh ====
/*
 Constants of the transceiver status and wake logic: pin vector slots,
 register offsets, field positions, reset values and timing counts.
 Assumes a 50 MHz hclk; included by its bare name.
*/
`ifndef CTS_MAP_SVH
`define CTS_MAP_SVH

// Clock period
`define CTS_CLK_NS          20

// Slots in the synchronised pin vector
`define CTS_PIN_TXD         0
`define CTS_PIN_TXD_DRV     1
`define CTS_PIN_EN          2
`define CTS_PIN_EN_DRV      3
`define CTS_PIN_LPS_N       4
`define CTS_PIN_LPS_DRV     5
`define CTS_PIN_WAKE        6
`define CTS_PIN_BUS_WAKE    7
`define CTS_PIN_BUS_RX      8
`define CTS_PIN_VSUP_UV     9
`define CTS_PIN_VCC_UV      10
`define CTS_PIN_VIO_UV      11
`define CTS_PIN_COUNT       12

// Register byte offsets
`define CTS_REG_STATUS      12'h000
`define CTS_REG_CTRL        12'h004

// Status field positions
`define CTS_ST_MODE_LSB     0
`define CTS_ST_COLD         8
`define CTS_ST_WAKE_REQ     9
`define CTS_ST_SRC_VALID    10
`define CTS_ST_SRC_LOCAL    11
`define CTS_ST_FAULT        12
`define CTS_ST_TXD          13

// Timing
`define CTS_UV_FILTER_NS    1000
`define CTS_UV_FILTER_CYC   ((`CTS_UV_FILTER_NS + `CTS_CLK_NS - 1) / `CTS_CLK_NS)
`define CTS_GOSLEEP_NS      1000
`define CTS_GOSLEEP_CYC     ((`CTS_GOSLEEP_NS + `CTS_CLK_NS - 1) / `CTS_CLK_NS)
`define CTS_TXD_EDGE_CLR    3'h4

// Reset values
`define CTS_CTRL_RESET      32'h0000_0032

`endif

// ==== hw/cts_pin_if.sv ====
/*
 Carrier of raw pin levels into the synchroniser and of the
 synchronised levels back to the control logic.
 Assumes both ends run on hclk.
*/
`default_nettype none

interface cts_pin_if #(parameter int unsigned W = 12);
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport syncer (input raw, output sync);
	modport user (output raw, input sync);
endinterface

`default_nettype wire

// ==== hw/cts_pin_sync.sv ====
/*
 Two-flop synchroniser for every pin-level input of the block.
 Assumes the raw levels are asynchronous to hclk.
*/
`default_nettype none

module cts_pin_sync #(
	parameter int unsigned W = 12
) (
	// Clock and reset
	input  wire logic  hclk,
	input  wire logic  hresetn,
	// Pins
	cts_pin_if.syncer  pins
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// Meta stage feeds only the second stage
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= pins.raw;
			sync_reg <= meta_reg;
		end
	end

	assign pins.sync = sync_reg;
endmodule

`default_nettype wire

// ==== hw/cts_pkg.sv ====
/*
 Types of the transceiver status and wake logic.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package cts_pkg;
	typedef enum logic [4:0]
	{
		mode_normal  = 5'b0_0001,
		mode_silent  = 5'b0_0010,
		mode_standby = 5'b0_0100,
		mode_gosleep = 5'b0_1000,
		mode_sleep   = 5'b1_0000
	} cts_mode_t;
endpackage

`default_nettype wire

// ==== hw/cts_top.sv ====
/*
 Status, wake and pin-control logic of a low-power CAN FD transceiver,
 with an AHB-Lite register slave.
 Assumes analog blocks deliver bus receive, bus wake and undervoltage
 levels asynchronously; pin "driven" inputs report whether a pin floats.
*/
`default_nettype none
`include "cts_map.svh"

module cts_top #(
	parameter int unsigned FAULT_W     = 4,
	parameter int unsigned UV_CYC      = `CTS_UV_FILTER_CYC,
	parameter logic [31:0] CTRL_RESET  = `CTS_CTRL_RESET
) (
	// Clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// AHB-Lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// Controller side pins
	input  wire logic               txd,
	input  wire logic               txd_driven,
	input  wire logic               en,
	input  wire logic               en_driven,
	input  wire logic               low_power_select_n,
	input  wire logic               low_power_select_driven,
	output logic                    rxd,
	output logic                    status_indicator_n,
	output logic                    status_indicator_oe,
	// System side pins and analog levels
	input  wire logic               local_pin_wakeup,
	input  wire logic               bus_wake,
	input  wire logic               bus_rx,
	input  wire logic               vsup_uv,
	input  wire logic               transceiver_supply_uv,
	input  wire logic               vio_uv,
	input  wire logic [FAULT_W-1:0] fault,
	output logic                    supply_control_out,
	output logic                    supply_control_oe
);
	localparam int unsigned PW = `CTS_PIN_COUNT + FAULT_W;

	cts_pin_if #(.W(PW)) pin_bus ();

	cts_pin_sync #(.W(PW)) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pins    (pin_bus)
	);

	assign pin_bus.raw = {fault, vio_uv, transceiver_supply_uv, vsup_uv, bus_rx, bus_wake,
		local_pin_wakeup, low_power_select_driven, low_power_select_n, en_driven, en,
		txd_driven, txd};

	function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic [15:0] lim);
		sat_inc = (v >= lim) ? v : v + 16'h0001;
	endfunction

	cts_pkg::cts_mode_t mode_reg;
	cts_pkg::cts_mode_t mode_next;
	logic [PW-1:0]  s;
	logic           txd_eff;
	logic           en_eff;
	logic           lps_eff;
	logic           txd_d_reg;
	logic           wake_d_reg;
	logic           bus_wake_d_reg;
	logic           vsup_uv_d_reg;
	logic           por_reg;
	logic           lwu_edge;
	logic           cold_evt;
	logic           wake_evt;
	logic           lp_mode;
	logic           enter_normal;
	logic           leave_normal;
	logic           uv_sustained;
	logic           fault_any;
	logic           cold_reg;
	logic           wake_req_reg;
	logic           src_valid_reg;
	logic           src_local_reg;
	logic           silent_lp_reg;
	logic [2:0]     tx_cnt_reg;
	logic           src_clr;
	logic [15:0]    vcc_cnt_reg;
	logic [15:0]    vio_cnt_reg;
	logic [15:0]    gs_cnt_reg;
	logic [31:0]    ctrl_reg;
	logic [31:0]    status_word;
	logic           wr_pend_reg;
	logic [11:0]    wr_addr_reg;

	assign s = pin_bus.sync;
	// Floating transmit pin is pulled recessive
	assign txd_eff = s[`CTS_PIN_TXD_DRV] ? s[`CTS_PIN_TXD] : 1'b1;
	// Undriven mode pins are pulled low
	assign en_eff  = s[`CTS_PIN_EN_DRV] & s[`CTS_PIN_EN];
	assign lps_eff = s[`CTS_PIN_LPS_DRV] & s[`CTS_PIN_LPS_N];
	assign fault_any = |s[PW-1:`CTS_PIN_COUNT];

	// Edge history
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			txd_d_reg      <= 1'b1;
			wake_d_reg     <= 1'b0;
			bus_wake_d_reg <= 1'b0;
			vsup_uv_d_reg  <= 1'b0;
			por_reg        <= 1'b1;
		end
		else
		begin
			txd_d_reg      <= txd_eff;
			wake_d_reg     <= s[`CTS_PIN_WAKE];
			bus_wake_d_reg <= s[`CTS_PIN_BUS_WAKE];
			vsup_uv_d_reg  <= s[`CTS_PIN_VSUP_UV];
			por_reg        <= 1'b0;
		end
	end

	// First cycle after release models battery power-up; the pin history
	// is ignored then, since the synchroniser still holds reset zeros
	assign lwu_edge = !por_reg && (s[`CTS_PIN_WAKE] != wake_d_reg);
	assign cold_evt = por_reg || (vsup_uv_d_reg && !s[`CTS_PIN_VSUP_UV]);
	assign wake_evt = lwu_edge || cold_evt ||
		(!por_reg && s[`CTS_PIN_BUS_WAKE] && !bus_wake_d_reg);
	assign lp_mode  = (mode_reg == cts_pkg::mode_standby) ||
		(mode_reg == cts_pkg::mode_gosleep) || (mode_reg == cts_pkg::mode_sleep);

	// Mode selection from both select pins together
	always_comb
	begin
		mode_next = mode_reg;
		case ({lps_eff, en_eff})
			2'b11: mode_next = cts_pkg::mode_normal;
			2'b10: mode_next = cts_pkg::mode_silent;
			2'b01:
			begin
				if (wake_req_reg)
					mode_next = cts_pkg::mode_standby;
				else if (mode_reg == cts_pkg::mode_sleep)
					mode_next = cts_pkg::mode_sleep;
				else if (mode_reg == cts_pkg::mode_gosleep && gs_cnt_reg >= ctrl_reg[15:0])
					mode_next = cts_pkg::mode_sleep;
				else
					mode_next = cts_pkg::mode_gosleep;
			end
			default:
			begin
				// A standby request leaves sleep only with a wake pending; normal and silent selects leave it at once
				if (mode_reg != cts_pkg::mode_sleep || wake_req_reg)
					mode_next = cts_pkg::mode_standby;
			end
		endcase
	end

	assign enter_normal = (mode_reg != cts_pkg::mode_normal) &&
		(mode_next == cts_pkg::mode_normal);
	assign leave_normal = (mode_reg == cts_pkg::mode_normal) &&
		(mode_next != cts_pkg::mode_normal);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mode_reg   <= cts_pkg::mode_standby;
			gs_cnt_reg <= 16'h0000;
		end
		else
		begin
			mode_reg <= mode_next;
			if (mode_reg == cts_pkg::mode_gosleep)
				gs_cnt_reg <= sat_inc(gs_cnt_reg, ctrl_reg[15:0]);
			else
				gs_cnt_reg <= 16'h0000;
		end
	end

	// Undervoltage filters, restarted when a wake request is raised
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			vcc_cnt_reg <= 16'h0000;
			vio_cnt_reg <= 16'h0000;
		end
		else
		begin
			if (!s[`CTS_PIN_VCC_UV] || (wake_evt && lp_mode))
				vcc_cnt_reg <= 16'h0000;
			else
				vcc_cnt_reg <= sat_inc(vcc_cnt_reg, 16'(UV_CYC));
			if (!s[`CTS_PIN_VIO_UV] || (wake_evt && lp_mode))
				vio_cnt_reg <= 16'h0000;
			else
				vio_cnt_reg <= sat_inc(vio_cnt_reg, 16'(UV_CYC));
		end
	end

	assign uv_sustained = (vcc_cnt_reg >= 16'(UV_CYC)) || (vio_cnt_reg >= 16'(UV_CYC));

	// Sticky flags; a set in the clearing cycle wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cold_reg     <= 1'b0;
			wake_req_reg <= 1'b0;
		end
		else
		begin
			if (cold_evt)
				cold_reg <= 1'b1;
			else if (enter_normal)
				cold_reg <= 1'b0;
			if (wake_evt && lp_mode)
				wake_req_reg <= 1'b1;
			else if (enter_normal || uv_sustained)
				wake_req_reg <= 1'b0;
		end
	end

	// Falls of the transmit bit only count in normal mode
	assign src_clr = leave_normal || uv_sustained ||
		(mode_reg == cts_pkg::mode_normal && txd_d_reg && !txd_eff &&
		tx_cnt_reg == `CTS_TXD_EDGE_CLR - 3'h1);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			src_valid_reg <= 1'b0;
			src_local_reg <= 1'b0;
			tx_cnt_reg    <= 3'h0;
		end
		else
		begin
			if (wake_evt && (!src_valid_reg || src_clr))
			begin
				src_valid_reg <= 1'b1;
				src_local_reg <= lwu_edge || cold_evt;
			end
			else if (src_clr)
				src_valid_reg <= 1'b0;
			if (mode_reg != cts_pkg::mode_normal || src_clr || !src_valid_reg)
				tx_cnt_reg <= 3'h0;
			else if (txd_d_reg && !txd_eff)
				tx_cnt_reg <= tx_cnt_reg + 3'h1;
		end
	end

	// Remember whether silent was entered from standby or sleep
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			silent_lp_reg <= 1'b0;
		else if (mode_next == cts_pkg::mode_silent && mode_reg != cts_pkg::mode_silent)
			silent_lp_reg <= (mode_reg == cts_pkg::mode_standby) ||
				(mode_reg == cts_pkg::mode_sleep);
	end

	// Pin outputs, all registered
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rxd                 <= 1'b1;
			status_indicator_n  <= 1'b1;
			status_indicator_oe <= 1'b1;
			supply_control_out  <= 1'b1;
			supply_control_oe   <= 1'b1;
		end
		else
		begin
			rxd <= lp_mode ? !wake_req_reg : s[`CTS_PIN_BUS_RX];
			status_indicator_oe <= (mode_reg != cts_pkg::mode_sleep);
			supply_control_out  <= 1'b1;
			supply_control_oe   <= (mode_reg != cts_pkg::mode_sleep);
			case (mode_reg)
				cts_pkg::mode_normal:
					status_indicator_n <= !(fault_any ||
						(src_valid_reg && src_local_reg));
				cts_pkg::mode_silent:
					status_indicator_n <= !(fault_any || (cold_reg && silent_lp_reg));
				cts_pkg::mode_standby:
					status_indicator_n <= !wake_req_reg;
				default:
					status_indicator_n <= 1'b1;
			endcase
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY
	assign status_word = {18'h0_0000, txd_eff, fault_any, src_local_reg, src_valid_reg,
		wake_req_reg, cold_reg, 3'h0, mode_reg};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
			ctrl_reg    <= CTRL_RESET;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (wr_pend_reg && wr_addr_reg == `CTS_REG_CTRL)
				ctrl_reg <= hwdata;
			wr_pend_reg <= 1'b0;
			hrdata      <= 32'h0000_0000;
			if (hsel && hready && htrans[1])
			begin
				wr_pend_reg <= hwrite;
				wr_addr_reg <= haddr[11:0];
				if (!hwrite && haddr[11:0] == `CTS_REG_STATUS)
					hrdata <= status_word;
				else if (!hwrite && haddr[11:0] == `CTS_REG_CTRL)
					hrdata <= ctrl_reg;
			end
		end
	end

	// Checks
	property p_txd_float;
		@(posedge hclk) disable iff (!hresetn)
		!s[`CTS_PIN_TXD_DRV] && $past(!s[`CTS_PIN_TXD_DRV]) |=> $stable(tx_cnt_reg) ||
		tx_cnt_reg == 3'h0;
	endproperty
	a_txd_float: assert property (p_txd_float) else $error("floating txd counted as edge");
	property p_cold_flags;
		@(posedge hclk) disable iff (!hresetn)
		cold_evt && lp_mode |=> cold_reg && wake_req_reg && src_valid_reg;
	endproperty
	a_cold_flags: assert property (p_cold_flags) else $error("cold start flags missing");
	property p_sleep_hiz;
		@(posedge hclk) disable iff (!hresetn)
		mode_reg == cts_pkg::mode_sleep |=> !status_indicator_oe && !supply_control_oe;
	endproperty
	a_sleep_hiz: assert property (p_sleep_hiz) else $error("pin driven in sleep");
	property p_inh_on;
		@(posedge hclk) disable iff (!hresetn)
		mode_reg != cts_pkg::mode_sleep |=> supply_control_oe && supply_control_out;
	endproperty
	a_inh_on: assert property (p_inh_on) else $error("supply control off when awake");
	property p_gts_refused;
		@(posedge hclk) disable iff (!hresetn)
		wake_req_reg |=> mode_reg != cts_pkg::mode_gosleep;
	endproperty
	a_gts_refused: assert property (p_gts_refused) else $error("go-to-sleep with request");
	property p_standby_wake;
		@(posedge hclk) disable iff (!hresetn)
		wake_req_reg && mode_reg == cts_pkg::mode_standby |=> !status_indicator_n && !rxd;
	endproperty
	a_standby_wake: assert property (p_standby_wake) else $error("wake not shown");
	property p_normal_clears;
		@(posedge hclk) disable iff (!hresetn)
		enter_normal && !cold_evt && !wake_evt |=> !cold_reg && !wake_req_reg;
	endproperty
	a_normal_clears: assert property (p_normal_clears) else $error("flags kept in normal");
	property p_leave_clr;
		@(posedge hclk) disable iff (!hresetn)
		leave_normal && !wake_evt |=> !src_valid_reg;
	endproperty
	a_leave_clr: assert property (p_leave_clr) else $error("source kept after normal");
	property p_first_src;
		@(posedge hclk) disable iff (!hresetn)
		src_valid_reg && !src_clr |=> src_valid_reg && $stable(src_local_reg);
	endproperty
	a_first_src: assert property (p_first_src) else $error("source overwritten");
	property p_lwu_req;
		@(posedge hclk) disable iff (!hresetn)
		lwu_edge && lp_mode && mode_next != cts_pkg::mode_normal &&
		mode_next != cts_pkg::mode_silent |=> wake_req_reg ##1 !rxd;
	endproperty
	a_lwu_req: assert property (p_lwu_req) else $error("local wake missed");
	property p_vsup_cold;
		@(posedge hclk) disable iff (!hresetn)
		$fell(s[`CTS_PIN_VSUP_UV]) |=> cold_reg;
	endproperty
	a_vsup_cold: assert property (p_vsup_cold) else $error("cold start missed");
	c_sleep_wake: cover property (@(posedge hclk) disable iff (!hresetn)
		mode_reg == cts_pkg::mode_sleep ##1 mode_reg == cts_pkg::mode_standby);
	c_cold_normal: cover property (@(posedge hclk) disable iff (!hresetn)
		cold_reg ##[1:200] mode_reg == cts_pkg::mode_normal);
	c_src_edges: cover property (@(posedge hclk) disable iff (!hresetn)
		src_valid_reg && mode_reg == cts_pkg::mode_normal ##1 !src_valid_reg);
endmodule

`default_nettype wire
